/* src/status_flag.sv */
// One status flag that hardware sets and software clears by read-one then write-zero.
`timescale 1ns/1ps
module status_flag #(parameter logic INIT = 1'b0)
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic reset,
    // Control.
    input  wire logic force_init,
    input  wire logic set,
    input  wire logic rd_seen,
    input  wire logic clr_req,
    // State.
    output logic      flag_q
);
    logic flag_d;
    logic armed_q;
    logic armed_d;

    always_comb
    begin
        flag_d  = flag_q;
        armed_d = armed_q;
        if (rd_seen && flag_q)
            armed_d = 1'b1;
        if (clr_req && armed_q)
        begin
            flag_d  = 1'b0;
            armed_d = 1'b0;
        end
        // A set in the clearing cycle wins.
        if (set)
            flag_d = 1'b1;
        if (force_init)
        begin
            flag_d  = INIT;
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            flag_q  <= INIT;
            armed_q <= 1'b0;
        end
        else
        begin
            flag_q  <= flag_d;
            armed_q <= armed_d;
        end
    end
endmodule

/* src/sync2.sv */
// Two-flop synchroniser for a level from another clock domain.
`timescale 1ns/1ps
module sync2
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic reset,
    // Level in and out.
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

/* src/uart_cfg.svh */
// Offsets, field positions, reset values and counts of the serial control and status unit.
//
// Summary of operation
// - Received multiproc flag 1 clears multiproc_irq_en.
// - Filtering suppresses receive requests and receive flags.
// - Filtering skips buffer transfer and error checks.
// - Flagged character wakes receiver, sets multiproc_flag_rx.
// - Transmit done requests when holding register empty.
// - Done request drops on flag or enable clear.
// - Clock output select only in asynchronous internal.
// - Clock source 1 makes the pin an input.
// - Asynchronous internal: 00 input ignored, 01 output.
// - Synchronous internal clock always drives the pin.
// - Asynchronous output clock runs at bit rate.
// - Status register layout, transmit empty down to multiproc.
// - Flags clear only by read-one then write-zero.
// - Transmit end and received multiproc are read-only.
// - Status loads 84 hex on reset, standby.
// - Transmit empty set by reset, disable, load.
// - Transmit empty 0 means holding register valid.
// - Filtering only in asynchronous multiprocessor format.
// - Transmit empty requests when enabled and set.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

`define UCS_OFF_CONTROL  8'h00
`define UCS_OFF_STATUS   8'h04
`define UCS_OFF_MODE     8'h08
`define UCS_OFF_TX_HOLD  8'h0C
`define UCS_OFF_RX_BUF   8'h10

`define UCS_CTL_TIE      7
`define UCS_CTL_RIE      6
`define UCS_CTL_TE       5
`define UCS_CTL_RE       4
`define UCS_CTL_MULTIPROC_IRQ_EN     3
`define UCS_CTL_TX_DONE_IRQ_EN     2
`define UCS_CTL_CKSRC    1
`define UCS_CTL_CKOUT    0

`define UCS_ST_TX_EMPTY_FLAG      7
`define UCS_ST_RX_FULL_FLAG      6
`define UCS_ST_OVERRUN_FLAG      5
`define UCS_ST_FER       4
`define UCS_ST_PER       3
`define UCS_ST_TRANSMIT_END_FLAG      2
`define UCS_ST_MPB       1
`define UCS_ST_MULTIPROC_FLAG_TX      0

`define UCS_MODE_SYNC    0
`define UCS_MODE_MPF     1

`define UCS_CONTROL_RST  8'h00
`define UCS_STATUS_RST   8'h84
`define UCS_MODE_RST     2'h0

`define UCS_HALF_BIT_CYC 8'h10
`define UCS_EXT_OVERSAMP 4'hF

`endif

/* src/uart_control_status.sv */
// Control and status registers, receive filtering and clock pin logic of the serial unit.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_control_status
    import uart_pkg::*;
(
    // Clock, reset and low power.
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        standby,
    input  wire logic        module_standby,
    // APB slave.
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive shifter events.
    input  wire rx_event_t   rx_evt,
    // Transmit shifter handshake.
    input  wire logic        tx_shift_ready,
    input  wire logic        tx_last_bit_done,
    output tx_load_t         tx_load,
    // Serial clock pin and bit tick.
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    output logic             bit_tick,
    // Controls to the shifters.
    output logic             tx_on,
    output logic             rx_on,
    output logic             sync_mode,
    // Interrupt requests.
    output logic             rx_full_irq,
    output logic             rx_error_irq,
    output logic             tx_empty_irq,
    output logic             tx_done_irq
);
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [1:0]  mode_q, mode_d;
    logic [7:0]  txh_q, txh_d;
    logic [7:0]  rxb_q, rxb_d;
    logic        mpb_q, mpb_d;
    logic        multiproc_flag_tx_q, multiproc_flag_tx_d;
    logic        transmit_end_flag_q, transmit_end_flag_d;
    logic        tx_empty_flag_d1_q;
    tx_load_t    txl_q, txl_d;
    logic        tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q;
    logic [7:0]  status_val;
    logic        low_power, acc, done, wr, rd, mapped;
    logic        wr_status, rd_status;
    logic        mp_active, rx_take, discard, good, mp_wake;
    logic        rx_full_flag_set, overrun_flag_set, fer_set, per_set;
    logic        load, tx_empty_flag_fall;
    logic [3:0]  irq_q, irq_d;
    logic        sck_s, sck_prev_q, sck_rise;
    logic        sck_o_q, sck_o_d, sck_oe_q, sck_oe_d;
    logic        tick_q, tick_d;
    logic [7:0]  div_q, div_d;
    logic [3:0]  os_q, os_d;
    clk_mode_t   cmode;

    assign low_power = standby | module_standby;
    assign acc       = psel & penable;
    assign done      = acc & pready_q;
    assign wr        = done & pwrite;
    assign rd        = done & ~pwrite;
    assign wr_status = wr & (paddr == `UCS_OFF_STATUS);
    assign rd_status = rd & (paddr == `UCS_OFF_STATUS);
    assign mapped    = (paddr == `UCS_OFF_CONTROL) | (paddr == `UCS_OFF_STATUS)
                     | (paddr == `UCS_OFF_MODE) | (paddr == `UCS_OFF_TX_HOLD)
                     | (paddr == `UCS_OFF_RX_BUF);

    // Status layout, transmit empty in the top bit.
    assign status_val = {tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q,
                         transmit_end_flag_q, mpb_q, multiproc_flag_tx_q};

    // Filtering applies only to asynchronous multiprocessor format.
    assign mp_active = ~mode_q[`UCS_MODE_SYNC] & mode_q[`UCS_MODE_MPF]
                     & ctrl_q[`UCS_CTL_MULTIPROC_IRQ_EN];
    assign rx_take   = rx_evt.valid & ctrl_q[`UCS_CTL_RE] & ~overrun_flag_q & ~fer_q;
    assign discard   = mp_active & ~rx_evt.multiproc_flag_rx;
    assign good      = rx_take & ~discard;
    assign mp_wake   = rx_take & mp_active & rx_evt.multiproc_flag_rx;
    assign overrun_flag_set  = good & rx_full_flag_q;
    assign fer_set   = good & ~rx_full_flag_q & rx_evt.frame_err & ~mode_q[`UCS_MODE_SYNC];
    assign per_set   = good & ~rx_full_flag_q & ~rx_evt.frame_err & rx_evt.parity_err
                     & ~mode_q[`UCS_MODE_SYNC];
    assign rx_full_flag_set  = good & ~rx_full_flag_q & ~fer_set & ~per_set;

    assign load      = ctrl_q[`UCS_CTL_TE] & ~tx_empty_flag_q & tx_shift_ready & ~txl_q.valid;
    assign tx_empty_flag_fall = tx_empty_flag_d1_q & ~tx_empty_flag_q;

    // Holding register empty; zero means unsent data is held.
    status_flag #(.INIT(1'b1)) u_tx_empty_flag
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .force_init (low_power),
        .set        (load | ~ctrl_q[`UCS_CTL_TE]),
        .rd_seen    (rd_status & prdata_q[`UCS_ST_TX_EMPTY_FLAG]),
        .clr_req    (wr_status & ~pwdata[`UCS_ST_TX_EMPTY_FLAG]),
        .flag_q     (tx_empty_flag_q)
    );

    status_flag #(.INIT(1'b0)) u_rx_full_flag
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .force_init (low_power),
        .set        (rx_full_flag_set),
        .rd_seen    (rd_status & prdata_q[`UCS_ST_RX_FULL_FLAG]),
        .clr_req    (wr_status & ~pwdata[`UCS_ST_RX_FULL_FLAG]),
        .flag_q     (rx_full_flag_q)
    );

    status_flag #(.INIT(1'b0)) u_overrun_flag
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .force_init (low_power),
        .set        (overrun_flag_set),
        .rd_seen    (rd_status & prdata_q[`UCS_ST_OVERRUN_FLAG]),
        .clr_req    (wr_status & ~pwdata[`UCS_ST_OVERRUN_FLAG]),
        .flag_q     (overrun_flag_q)
    );

    status_flag #(.INIT(1'b0)) u_fer
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .force_init (low_power),
        .set        (fer_set),
        .rd_seen    (rd_status & prdata_q[`UCS_ST_FER]),
        .clr_req    (wr_status & ~pwdata[`UCS_ST_FER]),
        .flag_q     (fer_q)
    );

    status_flag #(.INIT(1'b0)) u_per
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .force_init (low_power),
        .set        (per_set),
        .rd_seen    (rd_status & prdata_q[`UCS_ST_PER]),
        .clr_req    (wr_status & ~pwdata[`UCS_ST_PER]),
        .flag_q     (per_q)
    );

    sync2 u_sck_sync
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (sck_i),
        .dout    (sck_s)
    );

    assign sck_rise = sck_s & ~sck_prev_q;

    // Registers, receive path and transmit handoff.
    always_comb
    begin
        pready_d  = acc & ~pready_q;
        pslverr_d = acc & ~pready_q & ~mapped;
        prdata_d  = prdata_q;
        if (acc && !pready_q && !pwrite)
        begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                `UCS_OFF_CONTROL: prdata_d[7:0] = ctrl_q;
                `UCS_OFF_STATUS:  prdata_d[7:0] = status_val;
                `UCS_OFF_MODE:    prdata_d[1:0] = mode_q;
                `UCS_OFF_TX_HOLD: prdata_d[7:0] = txh_q;
                `UCS_OFF_RX_BUF:  prdata_d[7:0] = rxb_q;
                default:          prdata_d      = 32'h0000_0000;
            endcase
        end
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        txh_d  = txh_q;
        multiproc_flag_tx_d = multiproc_flag_tx_q;
        if (wr && paddr == `UCS_OFF_CONTROL)
            ctrl_d = pwdata[7:0];
        if (wr && paddr == `UCS_OFF_MODE)
            mode_d = pwdata[1:0];
        if (wr && paddr == `UCS_OFF_TX_HOLD)
            txh_d = pwdata[7:0];
        // Only the transmit multiproc bit takes written data.
        if (wr_status)
            multiproc_flag_tx_d = pwdata[`UCS_ST_MULTIPROC_FLAG_TX];
        if (mp_wake)
            ctrl_d[`UCS_CTL_MULTIPROC_IRQ_EN] = 1'b0;
        rxb_d = rxb_q;
        if (good && !rx_full_flag_q)
            rxb_d = rx_evt.data;
        mpb_d = mpb_q;
        if (good && mode_q[`UCS_MODE_MPF] && !mode_q[`UCS_MODE_SYNC])
            mpb_d = rx_evt.multiproc_flag_rx;
        transmit_end_flag_d = transmit_end_flag_q;
        if (tx_empty_flag_fall)
            transmit_end_flag_d = 1'b0;
        if (tx_last_bit_done && tx_empty_flag_q)
            transmit_end_flag_d = 1'b1;
        txl_d.valid = load;
        txl_d.data  = load ? txh_q : txl_q.data;
        txl_d.multiproc_flag_rx   = load ? multiproc_flag_tx_q : txl_q.multiproc_flag_rx;
        if (low_power)
        begin
            ctrl_d = `UCS_CONTROL_RST;
            transmit_end_flag_d = 1'(`UCS_STATUS_RST >> `UCS_ST_TRANSMIT_END_FLAG);
            mpb_d  = 1'b0;
            multiproc_flag_tx_d = 1'b0;
        end
        irq_d[0] = rx_full_flag_q & ctrl_q[`UCS_CTL_RIE] & ~mp_active;
        irq_d[1] = (overrun_flag_q | fer_q | per_q) & ctrl_q[`UCS_CTL_RIE] & ~mp_active;
        irq_d[2] = tx_empty_flag_q & ctrl_q[`UCS_CTL_TIE];
        irq_d[3] = transmit_end_flag_q & ctrl_q[`UCS_CTL_TX_DONE_IRQ_EN];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q    <= `UCS_CONTROL_RST;
            mode_q    <= `UCS_MODE_RST;
            txh_q     <= 8'h00;
            rxb_q     <= 8'h00;
            mpb_q     <= 1'b0;
            multiproc_flag_tx_q    <= 1'b0;
            transmit_end_flag_q    <= 1'b1;
            tx_empty_flag_d1_q <= 1'b1;
            txl_q     <= '0;
            irq_q     <= 4'h0;
        end
        else
        begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q    <= ctrl_d;
            mode_q    <= mode_d;
            txh_q     <= txh_d;
            rxb_q     <= rxb_d;
            mpb_q     <= mpb_d;
            multiproc_flag_tx_q    <= multiproc_flag_tx_d;
            transmit_end_flag_q    <= transmit_end_flag_d;
            tx_empty_flag_d1_q <= tx_empty_flag_q;
            txl_q     <= txl_d;
            irq_q     <= irq_d;
        end
    end

    // Clock source and pin direction.
    always_comb
    begin
        if (ctrl_q[`UCS_CTL_CKSRC])
            cmode = mode_q[`UCS_MODE_SYNC] ? CM_EXT_SYNC : CM_EXT_ASYNC;
        else if (mode_q[`UCS_MODE_SYNC])
            cmode = CM_INT_SYNC;
        else
            cmode = ctrl_q[`UCS_CTL_CKOUT] ? CM_INT_OUT : CM_INT_IN;
    end

    always_comb
    begin
        div_d   = (div_q == `UCS_HALF_BIT_CYC - 8'h01) ? 8'h00 : div_q + 8'h01;
        sck_o_d = sck_o_q;
        sck_oe_d = 1'b0;
        os_d    = os_q;
        tick_d  = 1'b0;
        unique case (cmode)
            CM_INT_IN, CM_INT_OUT, CM_INT_SYNC:
            begin
                // One pin period per bit.
                if (div_q == `UCS_HALF_BIT_CYC - 8'h01)
                begin
                    sck_o_d = ~sck_o_q;
                    tick_d  = sck_o_q;
                end
                sck_oe_d = (cmode != CM_INT_IN);
            end
            CM_EXT_ASYNC:
            begin
                // Sixteen rising pin edges make one bit.
                if (sck_rise)
                begin
                    os_d   = os_q + 4'h1;
                    tick_d = (os_q == `UCS_EXT_OVERSAMP);
                end
                sck_oe_d = 1'b0;
            end
            CM_EXT_SYNC:
            begin
                tick_d   = sck_rise;
                sck_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_q      <= 8'h00;
            sck_o_q    <= 1'b1;
            sck_oe_q   <= 1'b0;
            os_q       <= 4'h0;
            tick_q     <= 1'b0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            div_q      <= div_d;
            sck_o_q    <= sck_o_d;
            sck_oe_q   <= sck_oe_d;
            os_q       <= os_d;
            tick_q     <= tick_d;
            sck_prev_q <= sck_s;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign tx_load      = txl_q;
    assign sck_o        = sck_o_q;
    assign sck_oe       = sck_oe_q;
    assign bit_tick     = tick_q;
    assign tx_on        = ctrl_q[`UCS_CTL_TE];
    assign rx_on        = ctrl_q[`UCS_CTL_RE];
    assign sync_mode    = mode_q[`UCS_MODE_SYNC];
    assign rx_full_irq  = irq_q[0];
    assign rx_error_irq = irq_q[1];
    assign tx_empty_irq = irq_q[2];
    assign tx_done_irq  = irq_q[3];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_multiproc_irq_en_auto_clear: assert property (mp_wake |=> !ctrl_q[`UCS_CTL_MULTIPROC_IRQ_EN])
        else $error("multiproc enable not cleared");
    a_filter_no_flags: assert property (rx_take && discard |=>
        !$rose(rx_full_flag_q) && !$rose(fer_q) && !$rose(overrun_flag_q))
        else $error("flag set while filtering");
    a_filter_no_xfer: assert property (rx_take && discard |=> $stable(rxb_q))
        else $error("buffer loaded while filtering");
    a_wake_mpb_set: assert property (mp_wake && !low_power |=> mpb_q)
        else $error("received multiproc bit not set");
    a_tx_done_req: assert property ((tx_last_bit_done && tx_empty_flag_q && ctrl_q[`UCS_CTL_TX_DONE_IRQ_EN]
        && !wr && !low_power) ##1 (!wr && !low_power) |=> tx_done_irq)
        else $error("transmit done not requested");
    a_ext_pin_input: assert property ($past(ctrl_q[`UCS_CTL_CKSRC]) |-> !sck_oe)
        else $error("pin driven with external clock");
    a_sync_drives: assert property ($past(cmode == CM_INT_SYNC) |-> sck_oe)
        else $error("sync clock not driven");
    a_async_in_idle: assert property ($past(cmode == CM_INT_IN) |-> !sck_oe)
        else $error("pin driven in input setting");
    a_status_init: assert property (low_power |=> status_val == `UCS_STATUS_RST)
        else $error("status not at reset value");
    a_write_one_ign: assert property (wr_status && pwdata[`UCS_ST_RX_FULL_FLAG] && !rx_full_flag_q
        && !rx_full_flag_set |=> !rx_full_flag_q)
        else $error("flag set by software");
    a_transmit_end_flag_readonly: assert property (wr_status && !pwdata[`UCS_ST_TRANSMIT_END_FLAG] && transmit_end_flag_q
        && pwdata[`UCS_ST_TX_EMPTY_FLAG] && !low_power |=> transmit_end_flag_q)
        else $error("transmit end written");
    a_tx_empty_flag_on_load: assert property (load |=> tx_empty_flag_q ##1 tx_load.valid == 1'b0)
        else $error("empty flag not set at load");

    c_mp_wake: cover property (mp_wake ##1 rx_full_flag_q);
    c_tx_done: cover property ($rose(tx_done_irq));
    c_ext_tick: cover property (cmode == CM_EXT_ASYNC && bit_tick);
    c_overrun: cover property ($rose(overrun_flag_q));
endmodule

/* src/uart_pkg.sv */
// Types shared by the serial control and status unit.
package uart_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       multiproc_flag_rx;
        logic       frame_err;
        logic       parity_err;
    } rx_event_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       multiproc_flag_rx;
    } tx_load_t;

    typedef enum logic [2:0] {
        CM_INT_IN,
        CM_INT_OUT,
        CM_INT_SYNC,
        CM_EXT_ASYNC,
        CM_EXT_SYNC
    } clk_mode_t;

endpackage

/* test/serial_remote.sv */
// Remote serial party: sends received characters, takes transmit loads, makes a link clock.
`timescale 1ns/1ps
module serial_remote
    import uart_pkg::*;
#(parameter int DONE_CYC = 40)
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Commands from the bench.
    input  wire logic       cmd_send,
    input  wire logic [7:0] cmd_data,
    input  wire logic       cmd_mpb,
    input  wire logic       ext_en,
    // Block side.
    input  wire tx_load_t   tx_load,
    output rx_event_t       rx_evt,
    output logic            tx_shift_ready,
    output logic            tx_last_bit_done,
    output logic            sck_i,
    output logic [7:0]      last_tx
);
    int busy;

    // The link clock runs only while enabled and stands low otherwise.
    initial
    begin
        sck_i = 1'b0;
        #1.3;
        forever
        begin
            #80;
            sck_i = ext_en ? ~sck_i : 1'b0;
        end
    end

    assign tx_shift_ready = (busy == 0);

    // Idle receive events carry a changing pattern so stale data never looks valid.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_evt <= '0;
            busy <= 0;
            tx_last_bit_done <= 1'b0;
            last_tx <= 8'h00;
        end
        else
        begin
            rx_evt <= cmd_send ? {1'b1, cmd_data, cmd_mpb, 2'b00} : {1'b0, ~rx_evt[10:0]};
            tx_last_bit_done <= (busy == 1);
            if (tx_load.valid)
            begin
                busy <= DONE_CYC;
                last_tx <= tx_load.data;
            end
            else if (busy > 0)
                busy <= busy - 1;
        end
    end
endmodule

/* test/uart_control_status_tb_top.sv */
// Self-checking bench of the serial control and status unit.
`timescale 1ns/1ps
module uart_control_status_tb_top;
    import uart_pkg::*;
    logic        clk_sys, reset, standby, module_standby, psel, penable, pwrite, pready;
    logic        pslverr, perr, tx_shift_ready, tx_last_bit_done, sck_i, sck_o, sck_oe;
    logic        bit_tick, tx_on, rx_on, sync_mode, rx_full_irq, rx_error_irq;
    logic        tx_empty_irq, tx_done_irq, cmd_send, cmd_mpb, ext_en;
    logic [7:0]  paddr, cmd_data, last_tx;
    logic [31:0] pwdata, prdata, rd;
    rx_event_t   rx_evt;
    tx_load_t    tx_load;
    int          n_mismatch, tests_run, cycles, n, m;

    uart_control_status DUT
    (
        .clk_sys(clk_sys), .reset(reset), .standby(standby), .module_standby(module_standby),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt),
        .tx_shift_ready(tx_shift_ready), .tx_last_bit_done(tx_last_bit_done), .tx_load(tx_load),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .bit_tick(bit_tick), .tx_on(tx_on),
        .rx_on(rx_on), .sync_mode(sync_mode), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq)
    );
    serial_remote partner
    (
        .clk_sys(clk_sys), .reset(reset), .cmd_send(cmd_send), .cmd_data(cmd_data),
        .cmd_mpb(cmd_mpb), .ext_en(ext_en), .tx_load(tx_load), .rx_evt(rx_evt),
        .tx_shift_ready(tx_shift_ready), .tx_last_bit_done(tx_last_bit_done), .sck_i(sck_i),
        .last_tx(last_tx)
    );

    always #2.5 clk_sys = ~clk_sys;

    task final_report;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            final_report;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk(rd & {24'h0, msk}, {24'h0, e}, s);
    endtask

    task send(input logic [7:0] d, input logic multiproc_flag_rx);
        cmd_send <= 1'b1;
        cmd_data <= d;
        cmd_mpb <= multiproc_flag_rx;
        @(posedge clk_sys);
        cmd_send <= 1'b0;
        cyc(3);
    endtask

    task gap(input logic use_sck, output int g);
        logic prev, cur;
        int k, rises;
        prev = 1'b1;
        rises = 0;
        g = 0;
        for (k = 0; k < 2000 && rises < 2; k++)
        begin
            @(posedge clk_sys);
            cur = use_sck ? sck_o : bit_tick;
            if (rises == 1)
                g++;
            if (cur === 1'b1 && prev !== 1'b1)
                rises++;
            prev = cur;
        end
    endtask

    task t_regs;
        rchk(8'h00, 8'hFF, 8'h00, "control after reset");
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, perr}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped read");
    endtask

    task t_flags;
        wr(8'h00, 8'h20);
        wr(8'h04, 8'h00);
        rchk(8'h04, 8'hFF, 8'h84, "clear without read");
        wr(8'h04, 8'hFB);
        rchk(8'h04, 8'hFF, 8'h85, "ones written");
    endtask

    task t_tx;
        wr(8'h00, 8'hA4);
        cyc(2);
        chk({31'h0, tx_empty_irq}, 32'h1, "empty request");
        chk({31'h0, tx_done_irq}, 32'h1, "done request");
        chk({29'h0, tx_on, rx_on, sync_mode}, 32'h4, "shifter controls");
        wr(8'h0C, 8'h5A);
        rchk(8'h04, 8'hFF, 8'h85, "status before send");
        wr(8'h04, 8'h01);
        cyc(3);
        chk({24'h0, last_tx}, 32'h5A, "loaded data");
        rchk(8'h04, 8'hFF, 8'h81, "status after load");
        chk({31'h0, tx_done_irq}, 32'h0, "done withdrawn");
        for (n = 0; n < 200 && tx_done_irq !== 1'b1; n++)
            @(posedge clk_sys);
        chk({31'h0, tx_done_irq}, 32'h1, "done after last bit");
        rchk(8'h04, 8'hFF, 8'h85, "end flag set");
        wr(8'h00, 8'hA0);
        cyc(2);
        chk({31'h0, tx_done_irq}, 32'h0, "done enable off");
    endtask

    task t_mp;
        wr(8'h08, 8'h02);
        wr(8'h00, 8'h58);
        send(8'h33, 1'b0);
        rchk(8'h04, 8'h42, 8'h00, "filtered char");
        chk({31'h0, rx_full_irq}, 32'h0, "filtered request");
        send(8'h6C, 1'b1);
        rchk(8'h04, 8'h42, 8'h42, "flagged char");
        rchk(8'h00, 8'hFF, 8'h50, "filter enable cleared");
        chk({31'h0, rx_full_irq}, 32'h1, "wake request");
        rchk(8'h10, 8'hFF, 8'h6C, "wake data");
        wr(8'h04, 8'h01);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h18);
        send(8'h11, 1'b0);
        rchk(8'h04, 8'h40, 8'h40, "sync ignores filter");
        rchk(8'h10, 8'hFF, 8'h11, "sync data");
        chk({29'h0, tx_on, rx_on, sync_mode}, 32'h3, "sync controls");
        wr(8'h00, 8'h50);
        send(8'h22, 1'b0);
        rchk(8'h04, 8'h60, 8'h60, "overrun set");
        chk({31'h0, rx_error_irq}, 32'h1, "error request");
        rchk(8'h10, 8'hFF, 8'h11, "buffer kept on overrun");
    endtask

    task t_pin;
        logic [2:0] i;
        for (int j = 0; j < 8; j++)
        begin
            i = 3'(j);
            wr(8'h08, {7'h0, i[2]});
            wr(8'h00, {6'h0, i[1:0]});
            cyc(2);
            chk({31'h0, sck_oe}, {31'h0, ~i[1] & (i[2] | i[0])}, "pin drive");
        end
    endtask

    task t_rate;
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h01);
        gap(1'b1, n);
        gap(1'b0, m);
        chk(32'(n), 32'(m), "pin clock versus bit rate");
        chk(32'(m), 32'd32, "bit period");
        ext_en <= 1'b1;
        wr(8'h00, 8'h02);
        gap(1'b0, m);
        chk(32'(m), 32'd512, "external bit period");
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h02);
        gap(1'b0, m);
        chk(32'(m), 32'd32, "external sync bit period");
        ext_en <= 1'b0;
    endtask

    task t_standby;
        for (int j = 0; j < 2; j++)
        begin
            wr(8'h00, 8'hA4);
            standby <= (j == 0);
            module_standby <= (j == 1);
            @(posedge clk_sys);
            standby <= 1'b0;
            module_standby <= 1'b0;
            @(posedge clk_sys);
            rchk(8'h00, 8'hFF, 8'h00, "control after standby");
            rchk(8'h04, 8'hFF, 8'h84, "status after standby");
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        reset = 1'b1;
        {standby, module_standby, psel, penable, pwrite, cmd_send, cmd_mpb, ext_en} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmd_data = 8'h00;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_regs;
        t_flags;
        t_tx;
        t_mp;
        t_pin;
        t_rate;
        t_standby;
        final_report;
    end
endmodule
